//--- src/asp_pkg.sv
// constants, types and state layout of the async serial port control block
// assumes one system clock; the cpu reaches the control byte in special function register space

package asp_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTL  = 8'h98;
	localparam logic [7:0] ADDR_DATA = 8'h99;

	// ----------------------------------------------------------------
	// control register bit positions and reset
	// ----------------------------------------------------------------
	localparam int B_MODE = 7;
	localparam int B_ONE  = 6;
	localparam int B_MCE  = 5;
	localparam int B_REN  = 4;
	localparam int B_TB8  = 3;
	localparam int B_RB8  = 2;
	localparam int B_TI   = 1;
	localparam int B_RI   = 0;
	localparam logic [7:0] CTL_RESET  = 8'h40;
	localparam logic [7:0] RDATA_NONE = 8'h00;

	// ----------------------------------------------------------------
	// frame and counter sizes
	// ----------------------------------------------------------------
	localparam int         CNT_W       = 16;
	localparam int         IDX_W       = 4;
	localparam logic [3:0] LAST_IDX_8  = 4'h7;
	localparam logic [3:0] LAST_IDX_9  = 4'h8;
	localparam logic [3:0] NINTH_IDX   = 4'h8;
	localparam logic [3:0] IDX_FIRST   = 4'h0;
	localparam logic [3:0] IDX_STEP    = 4'h1;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CNT_STEP   = 16'h0001;
	localparam int         BIT_CYCLES_DEF = 347;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} asp_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asp_rx_e;

	typedef struct packed {
		logic mode;
		logic mce;
		logic ren;
		logic tb8;
		logic rb8;
		logic ti;
		logic ri;
	} asp_ctl_s;

	typedef struct packed {
		asp_ctl_s          ctl;
		asp_tx_e           tx_st;
		logic [CNT_W-1:0]  tx_cnt;
		logic [IDX_W-1:0]  tx_idx;
		logic [7:0]        tx_sh;
		logic              txd;
		asp_rx_e           rx_st;
		logic [CNT_W-1:0]  rx_cnt;
		logic [IDX_W-1:0]  rx_idx;
		logic [8:0]        rx_sh;
		logic [7:0]        rx_data;
		logic [7:0]        rdata;
		logic              irq;
	} asp_state_s;

endpackage

//--- src/asp_sync.sv
// three-stage synchroniser with agreement filter for one pin input
// assumes the input is asynchronous to clk_in; output changes only when stages two and three agree

`timescale 1ns/1ps

module asp_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic async_in,
	output logic      level_out
);

	// ----------------------------------------------------------------
	// stages: [0] first flop, [1] second, [2] third, [3] filtered level
	// ----------------------------------------------------------------
	logic [3:0] sync_q;
	logic [3:0] sync_d;

	always_comb begin
		sync_d    = sync_q;
		sync_d[0] = async_in;
		// first stage feeds only the second, never the filter
		sync_d[1] = sync_q[0];
		sync_d[2] = sync_q[1];
		if (sync_q[1] == sync_q[2]) begin
			sync_d[3] = sync_q[2];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_q <= {4{RESET_VAL}};
		end else begin
			sync_q <= sync_d;
		end
	end

	assign level_out = sync_q[3];

endmodule

//--- src/asp_ctrl.sv
// async serial port: control byte, transmitter, receiver and interrupt request
// assumes a cpu special function register port and idle-high serial line pins
//
// Functional notes
// - the frame format bit picks 8-bit frames when clear and 9-bit frames when set.
// - bit 6 of the control byte always reads one and writes to it are ignored.
// - in 8-bit mode with the check bit set the receive flag rises only on a high stop bit.
// - in 9-bit mode with the check bit set the receive flag rises only on a high ninth bit.
// - frames are accepted only while the receive enable bit is set.
// - in 9-bit mode the transmit ninth bit is sent as the ninth bit of each frame.
// - each received frame loads the received ninth bit with the stop bit or ninth data bit.
// - the transmit done flag sets as the stop bit begins, after the last data bit.
// - with the port interrupt enabled a set transmit done flag requests service.
// - the receive done flag sets when the stop bit is sampled, subject to qualification.
// - with the port interrupt enabled a set receive done flag requests service.

`timescale 1ns/1ps

module asp_ctrl #(
	parameter int BIT_CYCLES = asp_pkg::BIT_CYCLES_DEF
) (
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic       sfr_wr_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       port_int_en_in,
	input  wire logic       rxd_in,
	output logic      [7:0] sfr_rdata_out,
	output logic            txd_out,
	output logic            irq_out
);

	// ----------------------------------------------------------------
	// bit timing
	// ----------------------------------------------------------------
	localparam logic [15:0] CNT_FULL = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] CNT_HALF = 16'(BIT_CYCLES / 2);

	asp_pkg::asp_state_s q;
	asp_pkg::asp_state_s d;
	logic                rxd;
	logic                wr_ctl;
	logic                wr_data;
	logic                rx_sample;
	logic                rx_done;
	logic                rx_ok;
	logic                tx_tick;
	logic                tx_to_stop;
	logic [3:0]          last_idx;

	// ----------------------------------------------------------------
	// line input synchroniser
	// ----------------------------------------------------------------
	asp_sync #(
		.RESET_VAL (1'b1)
	) u_rx_sync (
		.clk_in    (mclk_in),
		.rst_n_in  (rst_n_in),
		.async_in  (rxd_in),
		.level_out (rxd)
	);

	// ----------------------------------------------------------------
	// decode and event terms
	// ----------------------------------------------------------------
	assign wr_ctl    = sfr_wr_in && (sfr_addr_in == asp_pkg::ADDR_CTL);
	assign wr_data   = sfr_wr_in && (sfr_addr_in == asp_pkg::ADDR_DATA);
	assign last_idx  = q.ctl.mode ? asp_pkg::LAST_IDX_9 : asp_pkg::LAST_IDX_8;
	assign rx_sample = (q.rx_st == asp_pkg::RX_STOP) && (q.rx_cnt == asp_pkg::CNT_ZERO);
	assign rx_done   = rx_sample && q.ctl.ren;
	// stop check in 8-bit mode, address filter in 9-bit mode
	assign rx_ok     = !q.ctl.mce || (q.ctl.mode ? q.rx_sh[asp_pkg::NINTH_IDX] : rxd);
	assign tx_tick   = (q.tx_cnt == asp_pkg::CNT_ZERO);
	assign tx_to_stop = (q.tx_st == asp_pkg::TX_DATA) && tx_tick && (q.tx_idx == last_idx);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;

		// control byte write; bit 6 has no storage
		if (wr_ctl) begin
			d.ctl.mode = sfr_wdata_in[asp_pkg::B_MODE];
			d.ctl.mce  = sfr_wdata_in[asp_pkg::B_MCE];
			d.ctl.ren  = sfr_wdata_in[asp_pkg::B_REN];
			d.ctl.tb8  = sfr_wdata_in[asp_pkg::B_TB8];
			d.ctl.rb8  = sfr_wdata_in[asp_pkg::B_RB8];
			d.ctl.ti   = sfr_wdata_in[asp_pkg::B_TI];
			d.ctl.ri   = sfr_wdata_in[asp_pkg::B_RI];
		end

		// transmitter; a data write while busy is dropped, software waits for the flag
		case (q.tx_st)
			asp_pkg::TX_IDLE: begin
				if (wr_data) begin
					d.tx_sh  = sfr_wdata_in;
					d.tx_cnt = CNT_FULL;
					d.tx_st  = asp_pkg::TX_START;
				end
			end
			asp_pkg::TX_START: begin
				if (tx_tick) begin
					d.tx_cnt = CNT_FULL;
					d.tx_idx = asp_pkg::IDX_FIRST;
					d.tx_st  = asp_pkg::TX_DATA;
				end else begin
					d.tx_cnt = q.tx_cnt - asp_pkg::CNT_STEP;
				end
			end
			asp_pkg::TX_DATA: begin
				if (tx_tick) begin
					d.tx_cnt = CNT_FULL;
					if (tx_to_stop) begin
						d.tx_st = asp_pkg::TX_STOP;
					end else begin
						d.tx_idx = q.tx_idx + asp_pkg::IDX_STEP;
					end
				end else begin
					d.tx_cnt = q.tx_cnt - asp_pkg::CNT_STEP;
				end
			end
			asp_pkg::TX_STOP: begin
				if (tx_tick) begin
					d.tx_st = asp_pkg::TX_IDLE;
				end else begin
					d.tx_cnt = q.tx_cnt - asp_pkg::CNT_STEP;
				end
			end
			default: begin
				d.tx_st = asp_pkg::TX_IDLE;
			end
		endcase

		// line level follows the next state so the pin moves with the state flop
		case (d.tx_st)
			asp_pkg::TX_START: d.txd = 1'b0;
			asp_pkg::TX_DATA: begin
				// ninth bit is taken live, so a late update still goes out
				if (d.tx_idx == asp_pkg::NINTH_IDX) begin
					d.txd = q.ctl.tb8;
				end else begin
					d.txd = d.tx_sh[d.tx_idx[2:0]];
				end
			end
			default: d.txd = 1'b1;
		endcase

		// receiver; centre sampling from the start edge
		case (q.rx_st)
			asp_pkg::RX_IDLE: begin
				if (q.ctl.ren && !rxd) begin
					d.rx_cnt = CNT_HALF;
					d.rx_st  = asp_pkg::RX_START;
				end
			end
			asp_pkg::RX_START: begin
				if (q.rx_cnt == asp_pkg::CNT_ZERO) begin
					// a glitch shorter than half a bit is not a start bit
					d.rx_st  = rxd ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
					d.rx_cnt = CNT_FULL;
					d.rx_idx = asp_pkg::IDX_FIRST;
				end else begin
					d.rx_cnt = q.rx_cnt - asp_pkg::CNT_STEP;
				end
			end
			asp_pkg::RX_DATA: begin
				if (q.rx_cnt == asp_pkg::CNT_ZERO) begin
					d.rx_sh[q.rx_idx] = rxd;
					d.rx_cnt          = CNT_FULL;
					if (q.rx_idx == last_idx) begin
						d.rx_st = asp_pkg::RX_STOP;
					end else begin
						d.rx_idx = q.rx_idx + asp_pkg::IDX_STEP;
					end
				end else begin
					d.rx_cnt = q.rx_cnt - asp_pkg::CNT_STEP;
				end
			end
			asp_pkg::RX_STOP: begin
				if (rx_sample) begin
					d.rx_st = asp_pkg::RX_IDLE;
				end else begin
					d.rx_cnt = q.rx_cnt - asp_pkg::CNT_STEP;
				end
			end
			default: begin
				d.rx_st = asp_pkg::RX_IDLE;
			end
		endcase
		if (!q.ctl.ren) begin
			d.rx_st = asp_pkg::RX_IDLE;
		end

		// hardware sets win over a software clear in the same cycle
		if (rx_done) begin
			d.rx_data = q.rx_sh[7:0];
			d.ctl.rb8 = q.ctl.mode ? q.rx_sh[asp_pkg::NINTH_IDX] : rxd;
			if (rx_ok) begin
				d.ctl.ri = 1'b1;
			end
		end
		if (tx_to_stop) begin
			d.ctl.ti = 1'b1;
		end

		d.irq = port_int_en_in && (d.ctl.ti || d.ctl.ri);

		if (sfr_addr_in == asp_pkg::ADDR_CTL) begin
			d.rdata = {d.ctl.mode, 1'b1, d.ctl.mce, d.ctl.ren,
			           d.ctl.tb8, d.ctl.rb8, d.ctl.ti, d.ctl.ri};
		end else if (sfr_addr_in == asp_pkg::ADDR_DATA) begin
			d.rdata = d.rx_data;
		end else begin
			d.rdata = asp_pkg::RDATA_NONE;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q         <= '0;
			q.tx_st   <= asp_pkg::TX_IDLE;
			q.rx_st   <= asp_pkg::RX_IDLE;
			q.txd     <= 1'b1;
			q.rx_sh   <= '0;
			q.rdata   <= asp_pkg::RDATA_NONE;
		end else begin
			q <= d;
		end
	end

	assign sfr_rdata_out = q.rdata;
	assign txd_out       = q.txd;
	assign irq_out       = q.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_last_tx_bit;
		(q.tx_st == asp_pkg::TX_DATA) && tx_tick && (q.tx_idx == last_idx);
	endsequence

	sequence s_stop_begins;
		(q.tx_st == asp_pkg::TX_STOP) && txd_out && q.ctl.ti;
	endsequence

	a_ctl_bit_six: assert property (
		(sfr_addr_in == asp_pkg::ADDR_CTL) |=> sfr_rdata_out[asp_pkg::B_ONE])
		else $error("control bit 6 read as zero");
	a_frame_length: assert property (
		(q.tx_st == asp_pkg::TX_DATA)
			|-> (q.tx_idx <= (q.ctl.mode ? asp_pkg::LAST_IDX_9 : asp_pkg::LAST_IDX_8)))
		else $error("transmit bit index beyond frame length");
	a_stop_check: assert property (
		$rose(q.ctl.ri) && !q.ctl.mode && $past(q.ctl.mce) && !$past(wr_ctl)
			|-> $past(rxd))
		else $error("receive flag set on low stop bit");
	a_ninth_filter: assert property (
		$rose(q.ctl.ri) && q.ctl.mode && $past(q.ctl.mce) && !$past(wr_ctl)
			|-> q.ctl.rb8)
		else $error("receive flag set on low ninth bit");
	a_rx_disabled: assert property (
		!q.ctl.ren |=> (q.rx_st == asp_pkg::RX_IDLE))
		else $error("receiver left idle while disabled");
	a_ninth_tx_bit: assert property (
		(d.tx_st == asp_pkg::TX_DATA) && (d.tx_idx == asp_pkg::NINTH_IDX)
			|=> txd_out == $past(q.ctl.tb8))
		else $error("ninth transmit bit mismatch");
	a_rb8_load: assert property (
		rx_done |=> q.ctl.rb8 == $past(q.ctl.mode ? q.rx_sh[asp_pkg::NINTH_IDX] : rxd))
		else $error("received ninth bit not loaded");
	a_ti_at_stop: assert property (
		s_last_tx_bit |=> s_stop_begins)
		else $error("transmit flag not set at stop bit");
	a_flags_sticky: assert property (
		(q.ctl.ti || q.ctl.ri) && !wr_ctl
			|=> (q.ctl.ti >= $past(q.ctl.ti)) && (q.ctl.ri >= $past(q.ctl.ri)))
		else $error("done flag cleared without a write");
	a_ri_set_wins: assert property (
		rx_done && rx_ok |=> q.ctl.ri)
		else $error("receive flag lost at stop sample");
	a_irq_request: assert property (
		port_int_en_in && (q.ctl.ti || q.ctl.ri) && !wr_ctl |=> irq_out)
		else $error("interrupt request missing");
	a_start_low: assert property (
		(q.tx_st == asp_pkg::TX_IDLE) && wr_data |=> !txd_out ##1 !txd_out)
		else $error("start bit not low");

endmodule

//--- sim/asp_remote.sv
// model of the remote serial transceiver on the line side of the port
// assumes its bit time matches the design's BIT_CYCLES and an idle-high line
`timescale 1ns/1ps
module asp_remote #(
	parameter int B = 16
) (
	input  wire logic mclk_in,
	input  wire logic txd_in,
	output logic      rxd_out
);
	logic [9:0] got_bits;
	int         n_frames;
	initial begin
		rxd_out = 1'b1;
		n_frames = 0;
	end
	// ------------------------------------------------------------
	// listener: ten bit-centre samples after the start edge
	// ------------------------------------------------------------
	// 8-bit frames leave the idle level in the tenth sample
	always begin
		@(negedge txd_in);
		repeat (B / 2) @(posedge mclk_in);
		for (int i = 0; i < 10; i++) begin
			repeat (B) @(posedge mclk_in);
			got_bits[i] = txd_in;
		end
		n_frames++;
	end
	// ------------------------------------------------------------
	// talker: start, n data bits lsb first, stop level, idle gap
	// ------------------------------------------------------------
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		@(posedge mclk_in);
		#1 rxd_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (B) @(posedge mclk_in);
			#1 rxd_out = d[i];
		end
		repeat (B) @(posedge mclk_in);
		#1 rxd_out = stop;
		repeat (B) @(posedge mclk_in);
		#1 rxd_out = 1'b1;
		repeat (B + 4) @(posedge mclk_in);
		// hand back off the edge so the caller's next drive is not in the edge step
		#1;
	endtask
endmodule

//--- sim/async_serial_port_control_bench.sv
// self-checking bench for the async serial port control block
// assumes the remote model on the line pins and a 40 MHz system clock
`timescale 1ns/1ps
module async_serial_port_control_bench;
	localparam int B = 16;
	logic       mclk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic       wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic       int_en = 1'b1;
	logic       rxd;
	logic [7:0] rdata;
	logic       txd;
	logic       irq;
	logic [7:0] v;
	int         n_errors = 0;
	int         tests_run = 0;

	always #12.5 mclk_in = ~mclk_in;

	asp_ctrl #(.BIT_CYCLES(B)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
		.port_int_en_in(int_en), .rxd_in(rxd), .sfr_rdata_out(rdata),
		.txd_out(txd), .irq_out(irq));
	asp_remote #(.B(B)) u_remote (.mclk_in(mclk_in), .txd_in(txd), .rxd_out(rxd));

	// ------------------------------------------------------------
	// access tasks: all entered one delay step after a rising edge
	// ------------------------------------------------------------
	task automatic report_and_stop();
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge mclk_in);
		#1 wr = 1'b0;
		// one idle edge so a following write never re-raises the strobe in the same step
		@(posedge mclk_in) #1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		@(posedge mclk_in);
		#1 chk(rdata, exp);
	endtask
	// bounded waits; running out counts a mismatch and ends the run
	task automatic wait_irq();
		int k;
		for (k = 0; k < 40 * B && irq !== 1'b1; k++) @(posedge mclk_in) #1;
		if (irq !== 1'b1) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task automatic wait_frames(input int n);
		int k;
		for (k = 0; k < 40 * B && u_remote.n_frames != n; k++) @(posedge mclk_in) #1;
		if (u_remote.n_frames != n) begin
			n_errors++;
			report_and_stop();
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge mclk_in);
		#1 rst_n_in = 1'b1;
		rdc(8'h98, 8'h40);
		rdc(8'h55, 8'h00);
		// 8-bit transmit, flag then software clear
		wrr(8'h98, 8'h10);
		wrr(8'h99, 8'ha5);
		wait_irq();
		rdc(8'h98, 8'h52);
		chk({7'h00, irq}, 8'h01);
		wrr(8'h98, 8'h10);
		chk({7'h00, irq}, 8'h00);
		wait_frames(1);
		chk(u_remote.got_bits[7:0], 8'ha5);
		chk({6'h00, u_remote.got_bits[9:8]}, 8'h03);
		// 9-bit transmit carries the ninth bit control
		// ninth bit low so it cannot be mistaken for the stop level
		wrr(8'h98, 8'h80);
		wrr(8'h99, 8'h3c);
		wait_irq();
		rdc(8'h98, 8'hc2);
		wrr(8'h98, 8'h80);
		wait_frames(2);
		chk(u_remote.got_bits[7:0], 8'h3c);
		chk({6'h00, u_remote.got_bits[9:8]}, 8'h02);
		// 8-bit receive, stop bit lands in the ninth-bit field
		wrr(8'h98, 8'h10);
		u_remote.send(9'h05a, 8, 1'b1);
		wait_irq();
		rdc(8'h98, 8'h55);
		rdc(8'h99, 8'h5a);
		int_en = 1'b0;
		@(posedge mclk_in) #1;
		@(posedge mclk_in) #1 chk({7'h00, irq}, 8'h00);
		int_en = 1'b1;
		wrr(8'h98, 8'h30);
		// stop check on: a low stop bit must not raise the flag
		u_remote.send(9'h011, 8, 1'b0);
		rdc(8'h98, 8'h70);
		rdc(8'h99, 8'h11);
		// stop check on: a high stop bit does raise the flag
		u_remote.send(9'h044, 8, 1'b1);
		rdc(8'h98, 8'h75);
		rdc(8'h99, 8'h44);
		// 9-bit address filter: only a high ninth bit raises the flag
		wrr(8'h98, 8'hb0);
		u_remote.send(9'h022, 9, 1'b1);
		rdc(8'h98, 8'hf0);
		u_remote.send(9'h133, 9, 1'b1);
		rdc(8'h98, 8'hf5);
		chk({7'h00, irq}, 8'h01);
		rdc(8'h99, 8'h33);
		// receiver off: frames ignored, bit 6 write ignored
		wrr(8'h98, 8'h00);
		u_remote.send(9'h077, 8, 1'b1);
		rdc(8'h98, 8'h40);
		rdc(8'h99, 8'h33);
		report_and_stop();
	end
endmodule
